/* src/ais_ctrl.sv */
// input select, burnout bias and offset cancellation controller with apb registers
//
// Operation
// RULE1: upper nibble positive input, lower nibble negative
// RULE2: nibble codes decode to channels and internals
// RULE3: scan sequencing overrides user input selection
// RULE4: code de selects the temperature diodes
// RULE5: burnout level selectable, writable any time
// RULE6: burnout runs regardless of conversion state
// RULE7: diode selection swaps burnout for diode bias
// RULE8: cancellation off gives plain conversions
// RULE9: two swapped conversions, output half difference
// RULE10: cancellation doubles conversion time per result
// RULE11: continuous with cancellation resets filter each conversion
// RULE12: continuous becomes gapless back-to-back one-shots; without cancellation the code runs afe_continuous from one start
// RULE13: external reference plus ref pins uses pins
// RULE14: settings sampled at each conversion pair start
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ais_ctrl
  import ais_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               scan_active,
  input  wire logic [7:0]         scan_code,
  input  wire logic               conv_done,
  input  wire logic signed [23:0] conv_data,
  output logic      [15:0]        pos_sel,
  output logic      [15:0]        neg_sel,
  output logic      [1:0]         burnout_level,
  output logic                    diode_bias_en,
  output logic                    ref_from_inputs,
  output logic                    conv_start,
  output logic                    filter_reset,
  output logic                    afe_continuous,
  output logic signed [23:0]      result,
  output logic                    result_strobe
);
  ais_regs_t          s;
  ais_regs_t          next_s;
  logic [7:0]         live_code;
  logic [7:0]         drive_code;
  logic               wr_ctrl;
  logic               start_req;
  logic               rd_result;
  logic               pair_done;
  logic signed [23:0] new_result;
  logic signed [24:0] diff;
  logic               diode_sel;
  ais_sel_if          pos_if ();
  ais_sel_if          neg_if ();

  ais_nibble_decode u_pos_dec (
    .sel (pos_if.dec)
  );

  ais_nibble_decode u_neg_dec (
    .sel (neg_if.dec)
  );

  assign pos_if.code = drive_code[7:4];  // see RULE1
  assign neg_if.code = drive_code[3:0];  // see RULE1

  always_comb begin
    next_s = s;
    next_s.conv_start    = 1'b0;
    next_s.filter_reset  = 1'b0;
    next_s.result_strobe = 1'b0;
    next_s.pready        = 1'b0;
    next_s.pslverr       = 1'b0;
    pair_done  = 1'b0;
    new_result = conv_data;
    diff       = 25'(s.first_data) - 25'(conv_data);
    live_code  = scan_active ? scan_code : s.input_select_code;  // see RULE3

    // register answer is prepared in the setup cycle, so access ends after one cycle
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        AIS_CTRL_ADDR: begin
          next_s.prdata[AIS_CTRL_CODE_LSB +: 8] = s.input_select_code;
          next_s.prdata[AIS_CTRL_BURN_LSB +: 2] = s.burn_level;
          next_s.prdata[AIS_CTRL_AZ_BIT]        = s.offset_cancel_enable;
          next_s.prdata[AIS_CTRL_CSEL_LSB +: 2] = s.conversion_selection;
          next_s.prdata[AIS_CTRL_VREF_BIT]      = s.vref_select;
        end
        AIS_STATUS_ADDR: begin
          next_s.prdata[1:0]   = s.state;
          next_s.prdata[2]     = s.result_ready;
          next_s.prdata[3]     = s.diode_bias_en;
          next_s.prdata[4]     = s.ref_from_inputs;
          next_s.prdata[6:5]   = s.burnout_level;
          next_s.prdata[15:8]  = drive_code;
        end
        AIS_RESULT_ADDR: begin
          next_s.prdata[23:0]  = s.result;
          next_s.prdata[31:24] = {8{s.result[23]}};
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end

    wr_ctrl   = psel && penable && s.pready && pwrite && (paddr == AIS_CTRL_ADDR);
    rd_result = psel && penable && s.pready && !pwrite && (paddr == AIS_RESULT_ADDR);
    start_req = wr_ctrl && pwdata[AIS_CTRL_START_BIT];
    if (wr_ctrl) begin
      next_s.input_select_code    = pwdata[AIS_CTRL_CODE_LSB +: 8];
      next_s.burn_level           = pwdata[AIS_CTRL_BURN_LSB +: 2];  // see RULE5
      next_s.offset_cancel_enable = pwdata[AIS_CTRL_AZ_BIT];
      next_s.conversion_selection = pwdata[AIS_CTRL_CSEL_LSB +: 2];
      next_s.vref_select          = pwdata[AIS_CTRL_VREF_BIT];
    end
    if (rd_result) begin
      next_s.result_ready = 1'b0;
    end

    unique case (s.state)
      AIS_IDLE: begin
        if (start_req && (pwdata[AIS_CTRL_CSEL_LSB +: 2] == AIS_CSEL_ONESHOT ||
                          pwdata[AIS_CTRL_CSEL_LSB +: 2] == AIS_CSEL_CONT)) begin
          // settings freeze here so a later write only affects the next result
          next_s.lat_code   = scan_active ? scan_code : pwdata[AIS_CTRL_CODE_LSB +: 8];  // see RULE14
          next_s.lat_az     = pwdata[AIS_CTRL_AZ_BIT];  // see RULE14
          next_s.lat_cont   = pwdata[AIS_CTRL_CSEL_LSB +: 2] == AIS_CSEL_CONT;
          next_s.afe_continuous = !pwdata[AIS_CTRL_AZ_BIT] && next_s.lat_cont;  // see RULE8
          next_s.conv_start = 1'b1;
          next_s.state      = AIS_FIRST;
        end
      end
      AIS_FIRST: begin
        if (conv_done) begin
          if (s.lat_az) begin
            // swapped conversion starts on the cycle after the done, no idle gap
            next_s.first_data   = conv_data;  // see RULE9
            next_s.conv_start   = 1'b1;  // see RULE12
            next_s.filter_reset = 1'b1;  // see RULE11
            next_s.state        = AIS_SECOND;
          end else begin
            pair_done  = 1'b1;
            new_result = conv_data;  // see RULE8
            if (!(s.lat_cont && s.conversion_selection == AIS_CSEL_CONT)) begin
              next_s.afe_continuous = 1'b0;
              next_s.state          = AIS_IDLE;
            end
          end
        end
      end
      AIS_SECOND: begin
        if (conv_done) begin
          pair_done  = 1'b1;
          new_result = diff[24:1];  // see RULE9
          if (s.lat_cont && s.conversion_selection == AIS_CSEL_CONT) begin
            // continuous mode is replaced by chained one-shot pairs
            next_s.lat_code     = live_code;  // see RULE14
            next_s.lat_az       = s.offset_cancel_enable;  // see RULE14
            next_s.conv_start   = 1'b1;  // see RULE12
            next_s.filter_reset = 1'b1;  // see RULE11
            next_s.afe_continuous = !s.offset_cancel_enable;
            next_s.state        = AIS_FIRST;  // see RULE10
          end else begin
            next_s.state = AIS_IDLE;
          end
        end
      end
      default: begin
        next_s.state = AIS_IDLE;
      end
    endcase

    // a fresh result wins over a read that clears the ready flag
    if (pair_done) begin
      next_s.result        = new_result;
      next_s.result_ready  = 1'b1;
      next_s.result_strobe = 1'b1;
    end

    // second conversion of a pair swaps the two nibbles
    if (next_s.state == AIS_IDLE) begin
      drive_code = live_code;
    end else if (next_s.state == AIS_SECOND) begin
      drive_code = {next_s.lat_code[3:0], next_s.lat_code[7:4]};  // see RULE9
    end else begin
      drive_code = next_s.lat_code;
    end
    next_s.pos_sel = pos_if.onehot;  // see RULE2
    next_s.neg_sel = neg_if.onehot;  // see RULE2

    // either diode on either input counts, 8'hde being the usual pairing
    diode_sel = drive_code[7:4] == AIS_SEL_DIODE_P || drive_code[7:4] == AIS_SEL_DIODE_M ||
                drive_code[3:0] == AIS_SEL_DIODE_P || drive_code[3:0] == AIS_SEL_DIODE_M;  // see RULE4
    // burnout follows only the level and the selection, never the conversion state
    next_s.diode_bias_en = diode_sel;  // see RULE7
    next_s.burnout_level = diode_sel ? AIS_BURN_OFF : next_s.burn_level;  // see RULE6
    next_s.ref_from_inputs = (next_s.vref_select == AIS_VREF_EXT) &&
      ((drive_code[7:4] == AIS_SEL_REFP && drive_code[3:0] == AIS_SEL_REFM) ||
       (drive_code[7:4] == AIS_SEL_REFM && drive_code[3:0] == AIS_SEL_REFP));  // see RULE13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s                      <= '0;
      s.state                <= AIS_IDLE;
      s.input_select_code    <= AIS_CODE_RESET;
      s.burn_level           <= AIS_BURN_RESET;
      s.offset_cancel_enable <= AIS_AZ_RESET;
      s.conversion_selection <= AIS_CSEL_RESET;
      s.vref_select          <= AIS_VREF_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata          = s.prdata;
  assign pready          = s.pready;
  assign pslverr         = s.pslverr;
  assign pos_sel         = s.pos_sel;
  assign neg_sel         = s.neg_sel;
  assign burnout_level   = s.burnout_level;
  assign diode_bias_en   = s.diode_bias_en;
  assign ref_from_inputs = s.ref_from_inputs;
  assign conv_start      = s.conv_start;
  assign filter_reset    = s.filter_reset;
  assign afe_continuous  = s.afe_continuous;
  assign result          = s.result;
  assign result_strobe   = s.result_strobe;
endmodule

/* src/ais_pkg.sv */
// constants, register map and types for the input select and offset cancel control
package ais_pkg;
  localparam logic [7:0]  AIS_CTRL_ADDR    = 8'h00;
  localparam logic [7:0]  AIS_STATUS_ADDR  = 8'h04;
  localparam logic [7:0]  AIS_RESULT_ADDR  = 8'h08;

  localparam int          AIS_CTRL_CODE_LSB  = 0;
  localparam int          AIS_CTRL_BURN_LSB  = 8;
  localparam int          AIS_CTRL_AZ_BIT    = 10;
  localparam int          AIS_CTRL_CSEL_LSB  = 11;
  localparam int          AIS_CTRL_VREF_BIT  = 13;
  localparam int          AIS_CTRL_START_BIT = 14;

  localparam logic [7:0]  AIS_CODE_RESET  = 8'h01;
  localparam logic [1:0]  AIS_BURN_RESET  = 2'h0;
  localparam logic        AIS_AZ_RESET    = 1'b0;
  localparam logic [1:0]  AIS_CSEL_RESET  = 2'h0;
  localparam logic        AIS_VREF_RESET  = 1'b0;

  localparam logic [1:0]  AIS_BURN_OFF    = 2'h0;
  localparam logic [1:0]  AIS_CSEL_ONESHOT = 2'h2;
  localparam logic [1:0]  AIS_CSEL_CONT   = 2'h3;
  localparam logic        AIS_VREF_EXT    = 1'b0;

  localparam logic [3:0]  AIS_SEL_RESERVED = 4'ha;
  localparam logic [3:0]  AIS_SEL_REFP     = 4'hb;
  localparam logic [3:0]  AIS_SEL_REFM     = 4'hc;
  localparam logic [3:0]  AIS_SEL_DIODE_P  = 4'hd;
  localparam logic [3:0]  AIS_SEL_DIODE_M  = 4'he;

  typedef enum logic [1:0] {
    AIS_IDLE   = 2'b00,
    AIS_FIRST  = 2'b01,
    AIS_SECOND = 2'b11
  } ais_state_t;

  typedef struct packed {
    ais_state_t         state;
    logic [7:0]         input_select_code;
    logic [1:0]         burn_level;
    logic               offset_cancel_enable;
    logic [1:0]         conversion_selection;
    logic               vref_select;
    logic [7:0]         lat_code;
    logic               lat_az;
    logic               lat_cont;
    logic signed [23:0] first_data;
    logic signed [23:0] result;
    logic               result_ready;
    logic [15:0]        pos_sel;
    logic [15:0]        neg_sel;
    logic [1:0]         burnout_level;
    logic               diode_bias_en;
    logic               ref_from_inputs;
    logic               conv_start;
    logic               filter_reset;
    logic               afe_continuous;
    logic               result_strobe;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } ais_regs_t;
endpackage

/* src/ais_sel_if.sv */
// carrier between the controller and one nibble decoder
`timescale 1ns/1ps
interface ais_sel_if;
  logic [3:0]  code;
  logic [15:0] onehot;
  modport dec  (input code, output onehot);
  modport user (output code, input onehot);
endinterface

/* src/ais_nibble_decode.sv */
// decoder of one 4-bit input selection code into one-hot switch enables
`timescale 1ns/1ps
module ais_nibble_decode
  import ais_pkg::*;
(
  ais_sel_if.dec sel
);
  always_comb begin
    // reserved code opens every switch so the input floats rather than shorts
    if (sel.code == AIS_SEL_RESERVED) begin
      sel.onehot = 16'h0000;
    end else begin
      sel.onehot = 16'h0001 << sel.code;
    end
  end
endmodule

/* verif/ais_ctrl_checker.sv */
// concurrent checks on the input select controller ports
`timescale 1ns/1ps
module ais_ctrl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        conv_done,
  input wire logic [15:0] pos_sel,
  input wire logic [15:0] neg_sel,
  input wire logic [1:0]  burnout_level,
  input wire logic        diode_bias_en,
  input wire logic        ref_from_inputs,
  input wire logic        conv_start,
  input wire logic        filter_reset,
  input wire logic        afe_continuous,
  input wire logic        result_strobe
);
  logic        busy;
  logic [15:0] last_pos;
  logic [15:0] last_neg;
  // selection seen at the previous start, to judge the swapped second conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      last_pos <= 16'h0000;
      last_neg <= 16'h0000;
    end else if (conv_start) begin
      busy     <= 1'b1;
      last_pos <= pos_sel;
      last_neg <= neg_sel;
    end else if (conv_done) begin
      busy <= 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rsv; !pos_sel[10] && !neg_sel[10]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code closed a switch");
  property p_dio; diode_bias_en == (|{pos_sel[14:13], neg_sel[14:13]}); endproperty
  a_dio: assert property (p_dio) else $error("diode bias mismatch");
  property p_burn; diode_bias_en |-> burnout_level == 2'h0; endproperty
  a_burn: assert property (p_burn) else $error("burnout left on with diodes");
  property p_ref; ref_from_inputs |-> (pos_sel[11] && neg_sel[12]) || (pos_sel[12] && neg_sel[11]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference taken without ref pins");
  property p_swap; conv_start && filter_reset && !result_strobe
    |-> pos_sel == last_neg && neg_sel == last_pos; endproperty
  a_swap: assert property (p_swap) else $error("second conversion not swapped");
  property p_hold; busy && !conv_start |-> $stable(pos_sel) && $stable(neg_sel); endproperty
  a_hold: assert property (p_hold) else $error("selection moved mid conversion");
  property p_gap; conv_done |=> conv_start || result_strobe; endproperty
  a_gap: assert property (p_gap) else $error("idle gap after conversion");
  property p_fr; filter_reset |-> conv_start; endproperty
  a_fr: assert property (p_fr) else $error("filter reset without start");
  property p_nofr; afe_continuous |-> !filter_reset; endproperty
  a_nofr: assert property (p_nofr) else $error("filter reset in plain run");
  property p_strb; result_strobe |-> $past(conv_done); endproperty
  a_strb: assert property (p_strb) else $error("result without conversion");
  c_pair: cover property (result_strobe && filter_reset);
  c_dio: cover property (diode_bias_en);
  c_cont: cover property (afe_continuous && result_strobe);
endmodule
bind ais_ctrl ais_ctrl_checker ais_ctrl_checker_i (.*);

/* verif/ais_afe_model.sv */
// behavioural analog front end answering conversion starts
`timescale 1ns/1ps
module ais_afe_model (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          conv_start,
  input  wire logic          afe_continuous,
  output logic               conv_done,
  output logic signed [23:0] conv_data
);
  int   seed = 32211;
  int   cnt;
  logic run;
  logic cont;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run       <= 1'b0;
      cont      <= 1'b0;
      cnt       <= 0;
      conv_done <= 1'b0;
      conv_data <= 24'h000000;
    end else begin
      conv_done <= 1'b0;
      // data only holds with the done pulse, never looks valid afterwards
      if (conv_done) conv_data <= ~conv_data;
      if (conv_start) begin
        run  <= 1'b1;
        cont <= 1'b0;
        cnt  <= 2 + ($random(seed) & 15);
      end else if (cont && !afe_continuous) begin
        run <= 1'b0;
      end else if (run && cnt > 1) begin
        cnt  <= cnt - 1;
        cont <= cont | afe_continuous;
      end else if (run) begin
        conv_done <= 1'b1;
        conv_data <= 24'($random(seed));
        run       <= afe_continuous;
        cnt       <= 2 + ($random(seed) & 15);
      end
    end
  end
endmodule

/* verif/ais_ctrl_test.sv */
// self-checking bench for the input select controller
`timescale 1ns/1ps
module ais_ctrl_test;
  import ais_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        scan_active = 1'b0, pready, pslverr, diode_bias_en, ref_from_inputs, err;
  logic        conv_start, filter_reset, afe_continuous, result_strobe, conv_done;
  logic [7:0]  paddr = 8'h00, scan_code = 8'h00, c;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] pos_sel, neg_sel;
  logic [1:0]  burnout_level, b;
  logic signed [23:0] conv_data, result;
  logic signed [23:0] q[$];
  int          fail_count = 0, checks_done = 0, cycles = 0, starts = 0, seed = 32211, n;
  int          resets = 0;

  always #5 pclk = ~pclk;
  ais_ctrl ais_ctrl_i (.*);
  ais_afe_model ais_afe_model_i (.*);

  task results();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (conv_start === 1'b1) starts++;
    if (filter_reset === 1'b1) resets++;
    if (conv_done === 1'b1) q.push_back(conv_data);
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // waits for one delivered result; a missing one is a mismatch, not a hang
  task run();
    repeat (200) begin
      @(posedge pclk);
      if (result_strobe === 1'b1) return;
    end
    chk(1'b0, 1'b1);
  endtask
  function automatic logic [31:0] ctl(logic [7:0] x, logic [1:0] l, logic z, logic [1:0] m,
                                      logic v, logic s);
    return {17'h0, s, v, m, z, l, x};
  endfunction
  function automatic logic [15:0] sx(logic [3:0] x);
    return (x == AIS_SEL_RESERVED) ? 16'h0000 : 16'h0001 << x;
  endfunction
  function automatic logic dio(logic [7:0] x);
    return (x[7:4] inside {4'hd, 4'he}) || (x[3:0] inside {4'hd, 4'he});
  endfunction
  function automatic logic signed [23:0] half(logic signed [23:0] a, logic signed [23:0] d);
    return 24'((25'(a) - 25'(d)) >>> 1);
  endfunction

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AIS_CTRL_ADDR, 32'h0);
    chk(rd, 32'h00000001);
    chk(pos_sel, 16'h0001);
    chk(neg_sel, 16'h0002);
    apb(1'b0, 8'h0c, 32'h0);
    chk(err, 1'b1);
    for (n = 0; n < 16; n++) begin
      c = {4'(n), 4'(15 - n)};
      b = 2'($random(seed));
      apb(1'b1, AIS_CTRL_ADDR, ctl(c, b, 1'b0, 2'h0, 1'b0, 1'b0));
      repeat (2) @(posedge pclk);
      chk(pos_sel, sx(c[7:4]));
      chk(neg_sel, sx(c[3:0]));
      chk(burnout_level, dio(c) ? 2'h0 : b);
      chk(diode_bias_en, dio(c));
    end
    apb(1'b1, AIS_CTRL_ADDR, ctl(8'hde, 2'h3, 1'b0, 2'h0, 1'b0, 1'b0));
    repeat (2) @(posedge pclk);
    chk({pos_sel, neg_sel}, 32'h20004000);
    apb(1'b0, AIS_CTRL_ADDR, 32'h0);
    chk(rd, ctl(8'hde, 2'h3, 1'b0, 2'h0, 1'b0, 1'b0));
    for (n = 0; n < 2; n++) begin
      apb(1'b1, AIS_CTRL_ADDR, ctl(8'hbc, 2'h1, 1'b0, 2'h0, 1'(n), 1'b0));
      repeat (2) @(posedge pclk);
      chk(ref_from_inputs, 1'(n == 0));
    end
    scan_code <= 8'($random(seed));
    scan_active <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({pos_sel, neg_sel}, {sx(scan_code[7:4]), sx(scan_code[3:0])});
    scan_active <= 1'b0;
    for (n = 0; n < 2; n++) begin
      q.delete();
      starts = 0;
      apb(1'b1, AIS_CTRL_ADDR, ctl(8'h23, 2'h2, 1'(n), AIS_CSEL_ONESHOT, 1'b0, 1'b1));
      // a write in mid pair must leave this result alone
      if (n == 1) apb(1'b1, AIS_CTRL_ADDR, ctl(8'h45, 2'h2, 1'b0, 2'h0, 1'b0, 1'b0));
      run();
      chk(starts, n + 1);
      chk(result, (n == 1) ? half(q[0], q[1]) : q[0]);
      chk(burnout_level, 2'h2);
    end
    // status shows the code written mid pair, now live, and a result waiting
    apb(1'b0, AIS_STATUS_ADDR, 32'h0);
    chk(rd, 32'h00004544);
    apb(1'b0, AIS_RESULT_ADDR, 32'h0);
    chk(rd, 32'(half(q[0], q[1])));
    apb(1'b0, AIS_STATUS_ADDR, 32'h0);
    chk(rd, 32'h00004540);
    q.delete();
    starts = 0;
    resets = 0;
    apb(1'b1, AIS_CTRL_ADDR, ctl(8'h67, 2'h1, 1'b1, AIS_CSEL_CONT, 1'b0, 1'b1));
    run();
    chk(result, half(q[0], q[1]));
    run();
    // the chained start shares its edge with the strobe, so let the counters see it
    @(posedge pclk);
    chk(result, half(q[2], q[3]));
    chk(starts, 5);
    chk(resets, 4);
    apb(1'b1, AIS_CTRL_ADDR, ctl(8'h67, 2'h1, 1'b1, 2'h0, 1'b0, 1'b0));
    run();
    q.delete();
    starts = 0;
    apb(1'b1, AIS_CTRL_ADDR, ctl(8'h01, 2'h0, 1'b0, AIS_CSEL_CONT, 1'b0, 1'b1));
    run();
    chk(afe_continuous, 1'b1);
    run();
    chk(result, q[1]);
    chk(starts, 1);
    apb(1'b1, AIS_CTRL_ADDR, ctl(8'h01, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0));
    run();
    repeat (40) @(posedge pclk);
    results();
  end
endmodule
